// ===== port_t_pin_control_bench.sv
// Self-checking bench for the port T pin block
`timescale 1ns/1ns
module port_t_pin_control_bench;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [4:0] adr = 5'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic ce = 1'h1;
  logic [31:0] rdat;
  logic wreq;
  ptpc_pkg::ptpc_timer_t tm = '0;
  ptpc_pkg::ptpc_pulse_t pu = '0;
  ptpc_pkg::ptpc_pad_t pad;
  logic [7:0] pin;
  logic [7:0] cap;
  logic [7:0] got;
  int miscompares = 0;
  int n_tests = 0;
  // Row: [23] write, [22] byte lane off, [20:16] address, [15:8] data, [7:0] expected
  logic [23:0] rows [17] = '{24'h00003C, 24'h080000, 24'h0C0000, 24'h100000, 24'h140000,
    24'h1C0000, 24'h880F00, 24'h80A500, 24'h000035, 24'h040035, 24'h84FF00, 24'h040035,
    24'hC8FF00, 24'h08000F, 24'h180000, 24'h8C0F00, 24'h0C000F};
  always #10 clk = ~clk;
  ptpc_port_t dut (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .timer_in(tm), .pulse_in(pu), .pin_in(pin), .pad_out(pad),
    .timer_capture_in(cap));
  ptpc_pad_model pads (.pad(pad), .ext(8'h3C), .pin(pin));
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    be <= b;
    rd <= !w;
    wr <= w;
    // Look between edges so the answer is settled; the next edge accepts it
    @(negedge clk);
    while (wreq !== 1'h0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    got = rdat[7:0];
    @(posedge clk);
    rd <= 1'h0;
    wr <= 1'h0;
    if (n == 50) begin
      miscompares++;
      finish_test();
    end
    repeat (3) @(posedge clk);
  endtask : bus
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i][23], rows[i][20:16], rows[i][15:8], {3'h7, ~rows[i][22]});
      if (!rows[i][23]) chk("row read", rows[i][7:0], got);
    end
    chk("reduce", 8'h0F, pad.reduced_drive);
    $display("test rows done");
    bus(1, 5'h08, 8'h00, 4'hF);
    bus(1, 5'h10, 8'hFF, 4'hF);
    bus(1, 5'h14, 8'h0F, 4'hF);
    chk("pull up", 8'hF0, pad.pull_up_en);
    chk("pull down", 8'h0F, pad.pull_down_en);
    chk("capture", 8'hF0, cap);
    bus(1, 5'h08, 8'hFF, 4'hF);
    chk("pull on output", 8'h00, pad.pull_up_en | pad.pull_down_en);
    bus(1, 5'h08, 8'h00, 4'hF);
    chk("reduce input", 8'h00, pad.reduced_drive);
    $display("test pulls done");
    ce <= 1'h0;
    tm.enable <= 1'h1;
    tm.compare_mode <= 8'h40;
    tm.overflow_toggle <= 8'h20;
    tm.action_routed <= 8'h41;
    repeat (3) @(posedge clk);
    chk("frozen capture", 8'hF0, cap);
    ce <= 1'h1;
    repeat (3) @(posedge clk);
    chk("capture driven", 8'hB0, cap);
    tm.channel_out <= 8'h40;
    repeat (2) @(posedge clk);
    chk("timer drive", 8'hBF, pad.drive_oe_n);
    chk("timer level", 8'h40, pad.level_out & 8'h40);
    tm.action_routed <= 8'h61;
    repeat (2) @(posedge clk);
    chk("overflow toggle", 8'h9F, pad.drive_oe_n);
    bus(0, 5'h08, 8'h00, 4'hF);
    chk("dir kept", 8'h00, got);
    bus(1, 5'h1C, 8'h01, 4'hF);
    tm.compare_mode <= 8'h01;
    pu.channel_enable <= 5'h01;
    pu.channel_out <= 5'h01;
    repeat (2) @(posedge clk);
    chk("pulse owns", 8'h01, pad.level_out & 8'h01);
    tm.enable <= 1'h0;
    pu.channel_enable <= 5'h00;
    repeat (2) @(posedge clk);
    chk("override off", 8'hFF, pad.drive_oe_n);
    $display("test override done");
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    chk("reset pulls", 8'h00, pad.pull_up_en | pad.pull_down_en);
    bus(0, 5'h08, 8'h00, 4'hF);
    chk("reset dir", 8'h00, got);
    bus(0, 5'h1C, 8'h00, 4'hF);
    chk("reset route", 8'h00, got);
    bus(0, 5'h00, 8'h00, 4'hF);
    chk("reset data", 8'h3C, got);
    $display("test reset done");
    finish_test();
  end
endmodule : port_t_pin_control_bench

// ===== ptpc_pad_model.sv
// Pad model resolving each pin from drive, pulls and outside source
`timescale 1ns/1ns
module ptpc_pad_model (
  input wire ptpc_pkg::ptpc_pad_t pad,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.drive_oe_n[i]) pin[i] = pad.level_out[i];
      else if (pad.pull_up_en[i]) pin[i] = 1'h1;
      else if (pad.pull_down_en[i]) pin[i] = 1'h0;
      else pin[i] = ext[i];
    end
  end
endmodule : ptpc_pad_model

// ===== ptpc_pkg.sv
// Package with register map, reset values and carriers for the port T pin block
package ptpc_pkg;
  localparam int unsigned PINS = 8;
  localparam int unsigned PWM_PINS = 5;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  // Register indices as printed; byte address is four times the index
  localparam logic [2:0] IDX_OUTPUT_DATA = 3'h0;
  localparam logic [2:0] IDX_PIN_LEVEL = 3'h1;
  localparam logic [2:0] IDX_DIRECTION = 3'h2;
  localparam logic [2:0] IDX_DRIVE_REDUCE = 3'h3;
  localparam logic [2:0] IDX_PULL_ENABLE = 3'h4;
  localparam logic [2:0] IDX_PULL_SELECT = 3'h5;
  localparam logic [2:0] IDX_ROUTE_SELECT = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_DATA = {IDX_OUTPUT_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = {IDX_PIN_LEVEL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION = {IDX_DIRECTION, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DRIVE_REDUCE = {IDX_DRIVE_REDUCE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PULL_ENABLE = {IDX_PULL_ENABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PULL_SELECT = {IDX_PULL_SELECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ROUTE_SELECT = {IDX_ROUTE_SELECT, 2'h0};
  // Reset values
  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DRIVE_REDUCE = 8'h00;
  localparam logic [7:0] RST_PULL_ENABLE = 8'h00;
  localparam logic [7:0] RST_PULL_SELECT = 8'h00;
  localparam logic [4:0] RST_ROUTE_SELECT = 5'h00;
  localparam logic [7:0] RST_PIN_SYNC = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // Timer status feeding the pin multiplexer
  typedef struct packed {
    logic enable;
    logic [7:0] compare_mode;
    logic [7:0] overflow_toggle;
    logic [7:0] action_routed;
    logic [7:0] channel_out;
  } ptpc_timer_t;

  // Pulse-width module status feeding the pin multiplexer
  typedef struct packed {
    logic [4:0] channel_enable;
    logic [4:0] channel_out;
  } ptpc_pulse_t;

  // Pad control for all eight pins
  typedef struct packed {
    logic [7:0] level_out;
    logic [7:0] drive_oe_n;
    logic [7:0] reduced_drive;
    logic [7:0] pull_up_en;
    logic [7:0] pull_down_en;
  } ptpc_pad_t;
endpackage : ptpc_pkg

// ===== ptpc_port_t.sv
// Port T pin control with Avalon-MM register slave
`timescale 1ns/1ns

module ptpc_port_t (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [ptpc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ptpc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ptpc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ptpc_pkg::ptpc_timer_t timer_in,
  input wire ptpc_pkg::ptpc_pulse_t pulse_in,
  input wire logic [7:0] pin_in,
  output ptpc_pkg::ptpc_pad_t pad_out,
  output logic [7:0] timer_capture_in
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  logic [7:0] output_data_reg;
  logic [7:0] direction_reg;
  logic [7:0] drive_reduce_reg;
  logic [7:0] pull_enable_reg;
  logic [7:0] pull_select_reg;
  logic [4:0] route_select_reg;

  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;

  logic ack_reg;
  logic [ptpc_pkg::DATA_W-1:0] readdata_reg;
  logic [ptpc_pkg::DATA_W-1:0] readdata_next;

  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic lane0;

  logic [7:0] pulse_owns;
  logic [7:0] timer_owns;
  logic [7:0] pin_is_out;
  logic [7:0] data_view;
  logic [7:0] pulse_level;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // Bus handshake: every access waits exactly one cycle while ce is high
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~ack_reg;
  // A frozen clock enable keeps the master waiting even once the answer is armed
  assign avs_waitrequest = bus_req & ~(ack_reg & ce);
  assign avs_readdata = readdata_reg;

  // Writes take effect once, on the first cycle the request is seen with ce high
  assign wr_take = avs_write & ~ack_reg & ce;
  assign lane0 = avs_byteenable[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= bus_take;
    end
  end

  // Pin synchroniser; only the second stage is read
  // sync before read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= ptpc_pkg::RST_PIN_SYNC;
      pin_sync_reg <= ptpc_pkg::RST_PIN_SYNC;
    end else if (ce) begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign timer_capture_in = pin_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_data_reg <= ptpc_pkg::RST_OUTPUT_DATA;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_OUTPUT_DATA) begin
      output_data_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      direction_reg <= ptpc_pkg::RST_DIRECTION;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_DIRECTION) begin
      direction_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_reduce_reg <= ptpc_pkg::RST_DRIVE_REDUCE;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_DRIVE_REDUCE) begin
      drive_reduce_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_enable_reg <= ptpc_pkg::RST_PULL_ENABLE;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_PULL_ENABLE) begin
      pull_enable_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_select_reg <= ptpc_pkg::RST_PULL_SELECT;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_PULL_SELECT) begin
      pull_select_reg <= avs_writedata[7:0];
    end
  end

  // bit 4 stored as written; clearing it is up to software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_select_reg <= ptpc_pkg::RST_ROUTE_SELECT;
    end else if (wr_take && lane0 && avs_address == ptpc_pkg::ADDR_ROUTE_SELECT) begin
      route_select_reg <= avs_writedata[4:0];
    end
  end

  assign data_view = (direction_reg & output_data_reg) | (~direction_reg & pin_sync_reg);

  // Read mux; writes to the level register fall through to no store
  // level write ignored
  always_comb begin
    readdata_next = ptpc_pkg::READ_ZERO;
    unique case (avs_address)
      ptpc_pkg::ADDR_OUTPUT_DATA: readdata_next[7:0] = data_view;
      ptpc_pkg::ADDR_PIN_LEVEL: readdata_next[7:0] = pin_sync_reg;
      ptpc_pkg::ADDR_DIRECTION: readdata_next[7:0] = direction_reg;
      ptpc_pkg::ADDR_DRIVE_REDUCE: readdata_next[7:0] = drive_reduce_reg;
      ptpc_pkg::ADDR_PULL_ENABLE: readdata_next[7:0] = pull_enable_reg;
      ptpc_pkg::ADDR_PULL_SELECT: readdata_next[7:0] = pull_select_reg;
      ptpc_pkg::ADDR_ROUTE_SELECT: readdata_next[4:0] = route_select_reg;
      default: readdata_next = ptpc_pkg::READ_ZERO;
    endcase
  end

  // Read data is caught on the first cycle the request is seen with ce high and held to the answer
  // sync lag visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_reg <= ptpc_pkg::READ_ZERO;
    end else if (ce && avs_read && !ack_reg) begin
      readdata_reg <= readdata_next;
    end
  end

  // Per-pin ownership, direction and pad control
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      if (i < ptpc_pkg::PWM_PINS) begin : g_pwm
        assign pulse_owns[i] = route_select_reg[i] & pulse_in.channel_enable[i];
        assign pulse_level[i] = pulse_in.channel_out[i];
      end else begin : g_nopwm
        // Upper pins have no pulse channel to index
        assign pulse_owns[i] = 1'b0;
        assign pulse_level[i] = 1'b0;
      end

      assign timer_owns[i] = timer_in.enable
                             & (timer_in.compare_mode[i] | timer_in.overflow_toggle[i])
                             & timer_in.action_routed[i];

      assign pin_is_out[i] = pulse_owns[i] | timer_owns[i] | direction_reg[i];

      assign pad_out.level_out[i] = pulse_owns[i] ? pulse_level[i]
                                    : timer_owns[i] ? timer_in.channel_out[i]
                                    : output_data_reg[i];

      assign pad_out.drive_oe_n[i] = ~pin_is_out[i];

      assign pad_out.reduced_drive[i] = pin_is_out[i] & drive_reduce_reg[i];

      assign pad_out.pull_up_en[i] = ~pin_is_out[i] & pull_enable_reg[i]
                                     & ~pull_select_reg[i];
      assign pad_out.pull_down_en[i] = ~pin_is_out[i] & pull_enable_reg[i]
                                       & pull_select_reg[i];
    end
  endgenerate

  // no pin interrupt logic
  // Port T has no interrupt enable, so the shared select bit only picks the pull.

endmodule : ptpc_port_t

// ===== ptpc_port_t_properties.sv
// Checker for the port T pin block
`timescale 1ns/1ns
module ptpc_port_t_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ptpc_pkg::ptpc_timer_t timer_in,
  input wire ptpc_pkg::ptpc_pulse_t pulse_in,
  input wire logic [7:0] pin_in,
  input wire ptpc_pkg::ptpc_pad_t pad_out,
  input wire logic [7:0] timer_capture_in
);
  // Margin past the two-flop reset release
  logic [2:0] up_reg;
  logic ok;
  logic [7:0] towned;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  assign ok = &up_reg;
  assign towned = {8{timer_in.enable}} & (timer_in.compare_mode | timer_in.overflow_toggle)
    & timer_in.action_routed & ~{3'h0, pulse_in.channel_enable};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_taken;
    (avs_read | avs_write) && avs_waitrequest && ce && ok;
  endsequence
  chk_one_wait: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_idle_wait: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  chk_capture_pin: assert property (ok && $past(ce) && $past(ce, 2)
    |-> timer_capture_in == $past(pin_in, 2)) else $error("capture not pin");
  chk_level_read: assert property (s_taken and avs_read
    && avs_address == ptpc_pkg::ADDR_PIN_LEVEL
    |=> avs_readdata[7:0] == $past(timer_capture_in)) else $error("level read wrong");
  chk_high_zero: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_no_pull_out: assert property (0 ==
    (~pad_out.drive_oe_n & (pad_out.pull_up_en | pad_out.pull_down_en)))
    else $error("pull on output");
  chk_pull_excl: assert property ((pad_out.pull_up_en & pad_out.pull_down_en) == 8'h0)
    else $error("both pulls on");
  chk_timer_drive: assert property ((towned & pad_out.drive_oe_n) == 8'h0)
    else $error("timer pin not driven");
  chk_timer_level: assert property ((towned & pad_out.level_out) ==
    (towned & timer_in.channel_out)) else $error("timer level wrong");
endmodule : ptpc_port_t_chk
bind ptpc_port_t ptpc_port_t_chk u_chk (.clk, .rstn, .ce, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .timer_in, .pulse_in, .pin_in, .pad_out,
  .timer_capture_in);
